// ==== rtl/gpt_pkg.sv ====
// constants, register map and types of the 32-bit general purpose timer
package gpt_pkg;
    // byte addresses of the registers
    localparam logic [31:0] ADDR_LOAD = 32'hFFFF0320;
    localparam logic [31:0] ADDR_COUNT = 32'hFFFF0324;
    localparam logic [31:0] ADDR_CTRL = 32'hFFFF0328;
    localparam logic [31:0] ADDR_CLR = 32'hFFFF032C;
    localparam logic [31:0] ADDR_CAP = 32'hFFFF0330;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFFF0334;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFF0338;
    // reset values
    localparam logic [31:0] LOAD_RST = 32'h00000000;
    localparam logic [31:0] COUNT_RST = 32'hFFFFFFFF;
    localparam logic [31:0] CAP_RST = 32'h00000000;
    // count source codes
    localparam logic [2:0] CS_CORE = 3'h0;
    localparam logic [2:0] CS_LP_OSC = 3'h1;
    localparam logic [2:0] CS_PIN_A = 3'h2;
    localparam logic [2:0] CS_PIN_B = 3'h3;
    // count formats
    localparam logic [1:0] FMT_H23 = 2'h2;
    // clock-time field limits
    localparam logic [7:0] HUND_MAX = 8'h63;
    localparam logic [7:0] MINSEC_MAX = 8'h3B;
    localparam logic [7:0] HOUR23_MAX = 8'h17;
    localparam logic [7:0] HOUR255_MAX = 8'hFF;
    // sticky status bits
    localparam int ST_W = 2;
    localparam int ST_TMR = 0;
    localparam int ST_CAP = 1;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register layout
    typedef struct packed {
        logic [7:0] ps_val;
        logic ps_en;
        logic [2:0] rsvd;
        logic ps_flag;
        logic irq_src;
        logic cap_en;
        logic [4:0] evt_sel;
        logic [2:0] clk_sel;
        logic up;
        logic en;
        logic periodic;
        logic [1:0] fmt;
        logic [3:0] pre;
    } gpt_ctrl_t;
    localparam gpt_ctrl_t CTRL_RST = '0;
    // one counter step: timeout flag and next value
    typedef struct packed {
        logic wrap;
        logic [31:0] val;
    } gpt_step_t;
endpackage

// ==== rtl/gpt_timer32.sv ====
// 32-bit general purpose timer with prescaler, post-scaler, capture and AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
module gpt_timer32 #(
    parameter int PRE_W = 15,
    parameter int N_EVT = 32
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic CLK_EN_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    input wire logic LP_OSC_I,
    input wire logic EXT_PIN_A_I,
    input wire logic EXT_PIN_B_I,
    input wire logic LOW_POWER_I,
    input wire logic [N_EVT-1:0] IRQ_SRC_I,
    output logic IRQ_O
);
    localparam int ST_W_L = gpt_pkg::ST_W;
    // state
    gpt_pkg::gpt_ctrl_t ctrl_q;
    logic [31:0] load_q, cnt_q, cnt_d, cap_q, wdata_q, waddr_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [7:0] ps_cnt_q, ps_cnt_d, ps_next;
    logic [PRE_W-1:0] pre_cnt_q, pre_lim;
    logic [ST_W_L-1:0] stat_q, mask_q, stat_set, stat_clr;
    logic flag_q, aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [N_EVT-1:0] evt_prev_q;
    logic [2:0] s1_q, s2_q, s3_q, lvl_q, rise;

    // byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    // one clock-time step; fields hours:min:sec:hundredths, one byte each
    function automatic gpt_pkg::gpt_step_t hms_step(input logic [31:0] v, input logic up,
                                                    input logic [7:0] hmax);
        gpt_pkg::gpt_step_t r;
        logic [7:0] h, m, s, c;
        {h, m, s, c} = v;
        r.wrap = 1'b0;
        if (up) begin
            if (c < gpt_pkg::HUND_MAX) begin
                c = c + 8'h01;
            end else begin
                c = 8'h00;
                if (s < gpt_pkg::MINSEC_MAX) begin
                    s = s + 8'h01;
                end else begin
                    s = 8'h00;
                    if (m < gpt_pkg::MINSEC_MAX) begin
                        m = m + 8'h01;
                    end else begin
                        m = 8'h00;
                        if (h < hmax) begin
                            h = h + 8'h01;
                        end else begin
                            h = 8'h00;
                            r.wrap = 1'b1;
                        end
                    end
                end
            end
        end else begin
            if (c != 8'h00) begin
                c = c - 8'h01;
            end else begin
                c = gpt_pkg::HUND_MAX;
                if (s != 8'h00) begin
                    s = s - 8'h01;
                end else begin
                    s = gpt_pkg::MINSEC_MAX;
                    if (m != 8'h00) begin
                        m = m - 8'h01;
                    end else begin
                        m = gpt_pkg::MINSEC_MAX;
                        if (h != 8'h00) begin
                            h = h - 8'h01;
                        end else begin
                            h = hmax;
                            r.wrap = 1'b1;
                        end
                    end
                end
            end
        end
        r.val = {h, m, s, c};
        return r;
    endfunction

    // pin-side sources: three flops, a rising level counts once stages two and three agree high
    logic [2:0] pin_raw;
    assign pin_raw = {EXT_PIN_B_I, EXT_PIN_A_I, LP_OSC_I};
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
                lvl_q[g] <= 1'b0;
            end else if (CLK_EN_I) begin
                s1_q[g] <= pin_raw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    lvl_q[g] <= s2_q[g];
                end
            end
        end
        assign rise[g] = s2_q[g] & s3_q[g] & ~lvl_q[g];
    end

    // bus decode; readies drop while the clock enable freezes the block
    logic do_wr, ar_hs, wr_load, wr_ctrl, wr_clr, wr_stat, wr_mask, w_hit, r_hit;
    assign S_AXI_AWREADY_O = ~aw_full_q & CLK_EN_I;
    assign S_AXI_WREADY_O = ~w_full_q & CLK_EN_I;
    assign S_AXI_ARREADY_O = ~rvalid_q & CLK_EN_I;
    assign ar_hs = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign do_wr = aw_full_q & w_full_q & ~bvalid_q & CLK_EN_I;
    assign wr_load = do_wr & (waddr_q == gpt_pkg::ADDR_LOAD);
    assign wr_ctrl = do_wr & (waddr_q == gpt_pkg::ADDR_CTRL);
    assign wr_clr = do_wr & (waddr_q == gpt_pkg::ADDR_CLR);
    assign wr_stat = do_wr & (waddr_q == gpt_pkg::ADDR_IRQ_STAT);
    assign wr_mask = do_wr & (waddr_q == gpt_pkg::ADDR_IRQ_MASK);
    // count and capture take writes without effect
    assign w_hit = wr_load | wr_ctrl | wr_clr | wr_stat | wr_mask
                 | (waddr_q == gpt_pkg::ADDR_COUNT) | (waddr_q == gpt_pkg::ADDR_CAP);

    // control read view: live post-scaler count on top, reserved bits as zero
    gpt_pkg::gpt_ctrl_t ctrl_rd, ctrl_wr;
    always_comb begin
        ctrl_rd = ctrl_q;
        ctrl_rd.ps_val = ps_cnt_q;
        ctrl_rd.ps_flag = flag_q;
        ctrl_rd.rsvd = 3'h0;
        ctrl_wr = merge(ctrl_q, wdata_q, wstrb_q);
        ctrl_wr.rsvd = 3'h0;
        ctrl_wr.ps_flag = 1'b0;
    end

    // read mux; write-only registers read as zero
    logic [31:0] rd_mux;
    assign r_hit = (S_AXI_ARADDR_I == gpt_pkg::ADDR_LOAD) | (S_AXI_ARADDR_I == gpt_pkg::ADDR_CLR)
                 | (S_AXI_ARADDR_I == gpt_pkg::ADDR_COUNT) | (S_AXI_ARADDR_I == gpt_pkg::ADDR_CTRL)
                 | (S_AXI_ARADDR_I == gpt_pkg::ADDR_CAP) | (S_AXI_ARADDR_I == gpt_pkg::ADDR_IRQ_STAT)
                 | (S_AXI_ARADDR_I == gpt_pkg::ADDR_IRQ_MASK);
    assign rd_mux = (S_AXI_ARADDR_I == gpt_pkg::ADDR_COUNT) ? cnt_q :
                    (S_AXI_ARADDR_I == gpt_pkg::ADDR_CTRL) ? ctrl_rd :
                    (S_AXI_ARADDR_I == gpt_pkg::ADDR_CAP) ? cap_q :
                    (S_AXI_ARADDR_I == gpt_pkg::ADDR_IRQ_STAT) ? 32'(stat_q) :
                    (S_AXI_ARADDR_I == gpt_pkg::ADDR_IRQ_MASK) ? 32'(mask_q) : 32'h00000000;

    // bus channel state; address and data may arrive in either order
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            waddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= gpt_pkg::RESP_OKAY;
            rresp_q <= gpt_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (CLK_EN_I) begin
            if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
                aw_full_q <= 1'b1;
                waddr_q <= S_AXI_AWADDR_I;
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
            if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
                w_full_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_hit ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= r_hit ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;

    // source select; core clock stops in low-power mode, the others run on
    logic src_tick, pre_hit, cnt_tick, timeout;
    assign src_tick = (ctrl_q.clk_sel == gpt_pkg::CS_CORE) ? ~LOW_POWER_I :
                      (ctrl_q.clk_sel == gpt_pkg::CS_LP_OSC) ? rise[0] :
                      (ctrl_q.clk_sel == gpt_pkg::CS_PIN_A) ? rise[1] :
                      (ctrl_q.clk_sel == gpt_pkg::CS_PIN_B) ? rise[2] : 1'b0;
    // divide by two to the code; codes between the documented ones follow the same law
    assign pre_lim = PRE_W'((32'h00000001 << ctrl_q.pre) - 32'h00000001);
    assign pre_hit = src_tick & (pre_cnt_q == pre_lim);
    assign cnt_tick = ctrl_q.en & pre_hit;

    // next count value in binary or clock-time format
    gpt_pkg::gpt_step_t step_bin, step_hms, step;
    assign step_bin = ctrl_q.up ? gpt_pkg::gpt_step_t'({1'b0, cnt_q} + 33'h000000001) :
                      {cnt_q == 32'h00000000, cnt_q - 32'h00000001};
    assign step_hms = hms_step(cnt_q, ctrl_q.up, (ctrl_q.fmt == gpt_pkg::FMT_H23) ?
                               gpt_pkg::HOUR23_MAX : gpt_pkg::HOUR255_MAX);
    // reserved format code counts as binary
    assign step = ctrl_q.fmt[1] ? step_hms : step_bin;
    assign timeout = cnt_tick & step.wrap;

    // counter: clear write reloads at once, periodic mode reloads on timeout
    always_comb begin
        cnt_d = cnt_q;
        if (wr_clr) begin
            cnt_d = load_q;
        end else if (cnt_tick) begin
            cnt_d = (timeout & ctrl_q.periodic) ? load_q : step.val;
        end
    end

    // post-scaler; target zero means 256 timeouts since the byte wraps
    logic ps_match, ps_step;
    assign ps_next = ps_cnt_q + 8'h01;
    assign ps_step = timeout & ctrl_q.ps_en;
    assign ps_match = ps_step & (ps_next == ctrl_q.ps_val);
    always_comb begin
        ps_cnt_d = ps_cnt_q;
        if (wr_ctrl & wstrb_q[3]) begin
            ps_cnt_d = 8'h00;
        end else if (ps_match) begin
            ps_cnt_d = 8'h00;
        end else if (ps_step) begin
            ps_cnt_d = ps_next;
        end
    end

    // events: timer interrupt source and capture on first assertion
    logic tmr_evt, cap_hit;
    assign tmr_evt = ctrl_q.irq_src ? ps_match : timeout;
    assign cap_hit = ctrl_q.cap_en & IRQ_SRC_I[ctrl_q.evt_sel]
                   & ~evt_prev_q[ctrl_q.evt_sel];
    assign stat_set = {cap_hit, tmr_evt};
    // clear register and a written one both drop the pending bit; a new event wins
    assign stat_clr = (wr_stat ? wdata_q[ST_W_L-1:0] : '0) | {1'b0, wr_clr};

    // timer state
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q <= gpt_pkg::CTRL_RST;
            load_q <= gpt_pkg::LOAD_RST;
            cnt_q <= gpt_pkg::COUNT_RST;
            cap_q <= gpt_pkg::CAP_RST;
            pre_cnt_q <= '0;
            ps_cnt_q <= 8'h00;
            flag_q <= 1'b0;
            evt_prev_q <= '0;
        end else if (CLK_EN_I) begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr;
            end
            if (wr_load) begin
                load_q <= merge(load_q, wdata_q, wstrb_q);
            end
            cnt_q <= cnt_d;
            if (!ctrl_q.en | wr_clr | pre_hit) begin
                pre_cnt_q <= '0;
            end else if (src_tick) begin
                pre_cnt_q <= pre_cnt_q + 1'b1;
            end
            ps_cnt_q <= ps_cnt_d;
            flag_q <= ps_match | (flag_q & ~wr_clr);
            evt_prev_q <= IRQ_SRC_I;
            if (cap_hit) begin
                cap_q <= cnt_q;
            end
        end
    end

    // interrupt status and mask
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stat_q <= '0;
            mask_q <= '0;
        end else if (CLK_EN_I) begin
            stat_q <= stat_set | (stat_q & ~stat_clr);
            if (wr_mask) begin
                mask_q <= wdata_q[ST_W_L-1:0];
            end
        end
    end
    assign IRQ_O = |(stat_q & mask_q);

    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I || !CLK_EN_I); // a frozen block holds every register
    AST_DOWN_STEP: assert property (cnt_tick & !ctrl_q.up & !ctrl_q.fmt[1] & !wr_clr
        & (cnt_q != 32'h00000000) |=> cnt_q == $past(cnt_q) - 32'h00000001)
        else $error("down count did not step by one");
    AST_UP_STEP: assert property (cnt_tick & ctrl_q.up & !ctrl_q.fmt[1] & !wr_clr
        & !timeout |=> cnt_q == $past(cnt_q) + 32'h00000001)
        else $error("up count did not step by one");
    AST_HALT: assert property (!ctrl_q.en & !wr_clr |=> $stable(cnt_q))
        else $error("counter moved while disabled");
    AST_CLR_RELOAD: assert property (wr_clr |=> cnt_q == $past(load_q))
        else $error("clear write did not reload");
    AST_CLR_IRQ: assert property (wr_clr & !tmr_evt |=> !stat_q[gpt_pkg::ST_TMR])
        else $error("clear write left interrupt pending");
    AST_CAPTURE: assert property (cap_hit |=> cap_q == $past(cnt_q))
        else $error("capture missed the count");
    AST_PS_FLAG: assert property (ps_match |=> flag_q && ps_cnt_q == 8'h00)
        else $error("post-scaler match not flagged");
    AST_DIRECT_IRQ: assert property (timeout & !ctrl_q.irq_src & CLK_EN_I
        |=> stat_q[gpt_pkg::ST_TMR])
        else $error("timeout did not raise interrupt");
    AST_PERIODIC: assert property (timeout & ctrl_q.periodic & !wr_clr
        |=> cnt_q == $past(load_q))
        else $error("periodic timeout did not reload");
    AST_CORE_SLEEP: assert property ((ctrl_q.clk_sel == gpt_pkg::CS_CORE)
        & LOW_POWER_I & !wr_clr |=> $stable(cnt_q))
        else $error("core source counted in low-power mode");
    COV_TIMEOUT: cover property (timeout ##1 IRQ_O);
    COV_CAPTURE: cover property (cap_hit);
    COV_PS_MATCH: cover property (ps_match & ctrl_q.irq_src);
    COV_HMS_WRAP: cover property (timeout & ctrl_q.fmt[1]);
endmodule

// ==== tb/gpt_timer32_test.sv ====
// self-checking bench of the 32-bit general purpose timer over its AXI4-Lite port
`timescale 1ns/100ps
module gpt_timer32_test;
    logic clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, low_pwr;
    logic [31:0] aw_a, w_d, ar_a, evt;
    logic [2:0] pins;
    wire logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
    wire logic [1:0] b_resp, r_resp;
    wire logic [31:0] r_d;
    int n_mismatch = 0;
    int compares = 0;

    gpt_timer32 dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
        .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_AWADDR_I(aw_a),
        .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy), .S_AXI_WDATA_I(w_d),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_r),
        .S_AXI_BRESP_O(b_resp), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
        .S_AXI_ARADDR_I(ar_a), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r),
        .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_resp), .LP_OSC_I(pins[2]),
        .EXT_PIN_A_I(pins[0]), .EXT_PIN_B_I(pins[1]), .LOW_POWER_I(low_pwr),
        .IRQ_SRC_I(evt), .IRQ_O(irq));

    // free running bench clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic test_done;
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // readies are looked at on the falling edge, so the rising edge that follows is
    // the handshake edge and the release by non-blocking assignment never races it
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
        bit ap, wp, at, wt;
        @(posedge clk);
        aw_v <= 1'b1;
        aw_a <= a;
        w_v <= 1'b1;
        w_d <= d;
        b_r <= 1'b1;
        ap = 1;
        wp = 1;
        while (ap || wp) begin
            @(negedge clk);
            at = ap && aw_rdy === 1'b1;
            wt = wp && w_rdy === 1'b1;
            @(posedge clk);
            if (at) begin
                aw_v <= 1'b0;
                ap = 0;
            end
            if (wt) begin
                w_v <= 1'b0;
                wp = 0;
            end
        end
        do @(negedge clk); while (b_v !== 1'b1);
        rs = b_resp;
        @(posedge clk);
        b_r <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk);
        ar_v <= 1'b1;
        ar_a <= a;
        r_r <= 1'b1;
        do @(negedge clk); while (ar_rdy !== 1'b1);
        @(posedge clk);
        ar_v <= 1'b0;
        do @(negedge clk); while (r_v !== 1'b1);
        d = r_d;
        rs = r_resp;
        @(posedge clk);
        r_r <= 1'b0;
    endtask

    task automatic w(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0] rs;
        rd(a, d, rs);
        chk(nm, e, d);
    endtask

    // rising edges on one count source, spaced wider than the synchroniser
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            pins[k] <= 1'b1;
            idle(3);
            pins[k] <= 1'b0;
            idle(3);
        end
        idle(8);
    endtask

    task automatic s_reset;
        logic [31:0] d;
        logic [1:0] rs;
        rc(gpt_pkg::ADDR_COUNT, 32'hFFFFFFFF, "count reset");
        rc(gpt_pkg::ADDR_CTRL, 32'h00000000, "control reset");
        rc(gpt_pkg::ADDR_CAP, 32'h00000000, "capture reset");
        rc(gpt_pkg::ADDR_LOAD, 32'h00000000, "load reads zero");
        rd(32'hFFFF0340, d, rs);
        chk("unmapped read resp", {30'h0, gpt_pkg::RESP_SLVERR}, {30'h0, rs});
    endtask

    // halted counter takes the load value only on a clear write
    task automatic s_reload;
        logic [1:0] rs;
        w(gpt_pkg::ADDR_LOAD, 32'h12345678);
        w(gpt_pkg::ADDR_CLR, 32'h0000DEAD);
        rc(gpt_pkg::ADDR_COUNT, 32'h12345678, "count after clear");
        idle(20);
        rc(gpt_pkg::ADDR_COUNT, 32'h12345678, "count while halted");
        wr(gpt_pkg::ADDR_COUNT, 32'h00000000, rs);
        chk("count write resp", {30'h0, gpt_pkg::RESP_OKAY}, {30'h0, rs});
        w(gpt_pkg::ADDR_CAP, 32'h0000FFFF);
        rc(gpt_pkg::ADDR_COUNT, 32'h12345678, "count ignores write");
        rc(gpt_pkg::ADDR_CAP, 32'h00000000, "capture ignores write");
    endtask

    task automatic s_capture;
        w(gpt_pkg::ADDR_CTRL, 32'h00025000);
        @(posedge clk);
        evt[5] <= 1'b1;
        idle(1);
        evt[5] <= 1'b0;
        idle(2);
        rc(gpt_pkg::ADDR_CAP, 32'h12345678, "captured count");
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000002, "capture status");
    endtask

    // pins and oscillator tick exactly once per rising edge, also in low power
    task automatic s_sources;
        low_pwr <= 1'b1;
        w(gpt_pkg::ADDR_LOAD, 32'h0000000A);
        w(gpt_pkg::ADDR_CTRL, 32'h00000480);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        pulse(0, 4);
        rc(gpt_pkg::ADDR_COUNT, 32'h00000006, "pin a down count");
        w(gpt_pkg::ADDR_CTRL, 32'h00000780);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        pulse(1, 3);
        rc(gpt_pkg::ADDR_COUNT, 32'h0000000D, "pin b up count");
        w(gpt_pkg::ADDR_CTRL, 32'h00000280);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        pulse(2, 2);
        rc(gpt_pkg::ADDR_COUNT, 32'h00000008, "oscillator count");
        w(gpt_pkg::ADDR_CTRL, 32'h00000080);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(10);
        rc(gpt_pkg::ADDR_COUNT, 32'h0000000A, "core halted in low power");
        low_pwr <= 1'b0;
    endtask

    // one pin step across the clock-time digit borders, for format codes 1, 2 and 3
    task automatic s_format;
        logic [31:0] ctl [3] = '{32'h000005A0, 32'h000004B0, 32'h00000590};
        logic [31:0] ld [3] = '{32'h00003B63, 32'h00000000, 32'h00003B63};
        logic [31:0] ex [3] = '{32'h00010000, 32'hFF3B3B63, 32'h00003B64};
        for (int i = 0; i < 3; i++) begin
            w(gpt_pkg::ADDR_CTRL, ctl[i]);
            w(gpt_pkg::ADDR_LOAD, ld[i]);
            w(gpt_pkg::ADDR_CLR, 32'h00000000);
            pulse(0, 1);
            rc(gpt_pkg::ADDR_COUNT, ex[i], "formatted count");
        end
    endtask

    task automatic s_prescale;
        logic [31:0] d;
        logic [1:0] rs;
        w(gpt_pkg::ADDR_LOAD, 32'h000003E8);
        w(gpt_pkg::ADDR_CTRL, 32'h00000084);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(320);
        rd(gpt_pkg::ADDR_COUNT, d, rs);
        chk("divide by 16", 32'h1, {31'h0, d >= 32'h000003D1 && d <= 32'h000003D5});
        w(gpt_pkg::ADDR_CTRL, 32'h0000008F);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(100);
        rc(gpt_pkg::ADDR_COUNT, 32'h000003E8, "divide by 32768");
    endtask

    task automatic s_irq;
        logic [31:0] d;
        logic [1:0] rs;
        w(gpt_pkg::ADDR_CTRL, 32'h00000000);
        w(gpt_pkg::ADDR_IRQ_STAT, 32'h00000003);
        w(gpt_pkg::ADDR_IRQ_MASK, 32'h00000001);
        w(gpt_pkg::ADDR_LOAD, 32'h00000003);
        w(gpt_pkg::ADDR_CTRL, 32'h000000C0);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(30);
        @(negedge clk);
        chk("irq on timeout", 32'h1, {31'h0, irq});
        rd(gpt_pkg::ADDR_COUNT, d, rs);
        chk("periodic range", 32'h1, {31'h0, d <= 32'h3});
        w(gpt_pkg::ADDR_CTRL, 32'h00000000);
        w(gpt_pkg::ADDR_CLR, 32'h00000001);
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000000, "status after clear");
        chk("irq after clear", 32'h0, {31'h0, irq});
        // masked: the sticky bit sets, the pin stays low until W1C
        w(gpt_pkg::ADDR_IRQ_MASK, 32'h00000000);
        w(gpt_pkg::ADDR_CTRL, 32'h000000C0);
        idle(20);
        w(gpt_pkg::ADDR_CTRL, 32'h00000000);
        chk("masked irq", 32'h0, {31'h0, irq});
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000001, "masked status");
        w(gpt_pkg::ADDR_IRQ_STAT, 32'h00000001);
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000000, "status w1c");
    endtask

    // free running up count wraps past the maximum without reloading
    task automatic s_wrap;
        logic [31:0] d;
        logic [1:0] rs;
        w(gpt_pkg::ADDR_LOAD, 32'hFFFFFFF0);
        w(gpt_pkg::ADDR_CTRL, 32'h00000180);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(40);
        w(gpt_pkg::ADDR_CTRL, 32'h00000000);
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000001, "up wrap status");
        rd(gpt_pkg::ADDR_COUNT, d, rs);
        chk("free run wrapped", 32'h1, {31'h0, d < 32'h00000100});
        w(gpt_pkg::ADDR_IRQ_STAT, 32'h00000003);
    endtask

    task automatic s_post;
        logic [31:0] d;
        logic [1:0] rs;
        w(gpt_pkg::ADDR_IRQ_MASK, 32'h00000001);
        w(gpt_pkg::ADDR_LOAD, 32'h00000001);
        w(gpt_pkg::ADDR_CTRL, 32'h038400C0);
        w(gpt_pkg::ADDR_CLR, 32'h00000000);
        idle(40);
        rd(gpt_pkg::ADDR_CTRL, d, rs);
        chk("compare flag", 32'h1, {31'h0, d[19]});
        rc(gpt_pkg::ADDR_IRQ_STAT, 32'h00000001, "post-scaler irq");
        w(gpt_pkg::ADDR_CTRL, 32'h03840000);
        rd(gpt_pkg::ADDR_CTRL, d, rs);
        chk("live post count", 32'h0, {24'h0, d[31:24]});
    endtask

    initial begin
        {rst_n, aw_v, w_v, b_r, ar_v, r_r, low_pwr} = '0;
        {aw_a, w_d, ar_a, evt} = '0;
        pins = 3'h0;
        idle(2);
        rst_n <= 1'b1;
        s_reset();
        s_reload();
        s_capture();
        s_sources();
        s_format();
        s_prescale();
        s_irq();
        s_wrap();
        s_post();
        test_done();
    end

    // the whole run needs well under 10000 cycles
    initial begin
        #(25 * 40000);
        n_mismatch++;
        test_done();
    end
endmodule
